/* File: gst_pkg.sv */
// constants and types shared by the gated sixteen-bit timer block
package gst_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int          GST_TMR_N      = 3;
  localparam int          GST_AW         = 8;
  localparam logic [2:0]  GST_INT_PAGE   = 3'h3;
  localparam logic [4:0]  GST_OFF_CTL    = 5'h00;
  localparam logic [4:0]  GST_OFF_GCTL   = 5'h04;
  localparam logic [4:0]  GST_OFF_CNTL   = 5'h08;
  localparam logic [4:0]  GST_OFF_CNTH   = 5'h0C;
  localparam logic [4:0]  GST_OFF_CKPS   = 5'h10;
  localparam logic [4:0]  GST_OFF_GPPS   = 5'h14;
  localparam logic [4:0]  GST_OFF_STAT   = 5'h00;
  localparam logic [4:0]  GST_OFF_MASK   = 5'h04;

  // ----------------------------------------------------------------
  // field layout of timer_control and gate_control
  // ----------------------------------------------------------------
  localparam int          GST_CS_LSB     = 6;
  localparam int          GST_PS_LSB     = 4;
  localparam int          GST_SOSC_BIT   = 3;
  localparam int          GST_SYNC_BIT   = 2;
  localparam int          GST_ON_BIT     = 0;
  localparam int          GST_GE_BIT     = 7;
  localparam int          GST_GPOL_BIT   = 6;
  localparam int          GST_GVAL_BIT   = 2;
  localparam int          GST_GSS_LSB    = 0;
  localparam logic [7:0]  GST_CTL_WMASK  = 8'hFD;
  localparam logic [7:0]  GST_GCTL_WMASK = 8'hC3;
  localparam logic [4:0]  GST_PPS_WMASK  = 5'h1F;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  GST_CTL_RST    = 8'h00;
  localparam logic [7:0]  GST_GCTL_RST   = 8'h00;
  localparam logic [15:0] GST_CNT_RST    = 16'h0000;
  localparam logic [4:0]  GST_PPS_RST    = 5'h00;
  localparam logic [1:0]  GST_INSTR_DIV  = 2'h3;

  // clock source encodings
  typedef enum logic [1:0] {
    GST_CS_INSTR = 2'h0,
    GST_CS_SYS   = 2'h1,
    GST_CS_PIN   = 2'h2,
    GST_CS_SOSC  = 2'h3
  } gst_cs_t;

  // per-timer state
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  gctl;
    logic [15:0] cnt;
    logic [4:0]  ckpps;
    logic [4:0]  gpps;
    logic [2:0]  pcnt;
    logic        clk_d;
    logic        clk_d2;
  } gst_tmr_t;

endpackage : gst_pkg

/* File: gst_timer.sv */
// three gated sixteen-bit timers behind an apb register slave
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - three identical timers, each with own control and count registers.
// - sixteen-bit count, read and written as low and high byte registers.
// - two-bit clock source field picks internal or external clock.
// - prescaler divides selected clock by one, two, four or eight.
// - prescale counter hidden from software; count byte writes clear it.
// - with sync disable set, the external clock skips the extra stage.
// - unsynchronised external clock counts in sleep; overflow wakes.
// - counter overflow sets the timer's interrupt flag.
// - count byte reads return a settled value, even when unsynchronised.
// - mode switch may lose or add one increment.
// - oscillator enable starts low-frequency oscillator; runs in sleep.
// - gate disabled means free counting; gate enable gates counting.
// - gate polarity picks gate level that allows counting.
// - gate open counts on rising clock edge, gate closed holds count.
// - two-bit gate source field picks the gate signal source.
module gst_timer
  import gst_pkg::*;
#(
  parameter int NPIN = 8
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [gst_pkg::GST_AW-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output      logic [31:0]               prdata,
  output      logic                      pready,
  output      logic                      pslverr,
  input  wire logic [NPIN-1:0]           pin_in,
  input  wire logic [2:0]                gate_aux,
  input  wire logic                      sleep,
  input  wire logic                      low_freq_osc_in,
  output      logic                      low_freq_osc_out,
  output      logic                      irq,
  output      logic                      wake
);

  import gst_pkg::*;

  // ----------------------------------------------------------------
  // state of the whole block
  // ----------------------------------------------------------------
  typedef struct packed {
    gst_tmr_t [GST_TMR_N-1:0] t;
    logic [GST_TMR_N-1:0]     status;
    logic [GST_TMR_N-1:0]     mask;
    logic [31:0]              prdata;
    logic [NPIN-1:0]          sync1;
    logic [NPIN-1:0]          sync2;
    logic                     sosc1;
    logic                     sosc2;
    logic [1:0]               idiv;
    logic                     osc_out;
  } gst_state_t;

  gst_state_t state_reg;
  gst_state_t state_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick one synchronised pin; indexes past the last pin read as zero
  function automatic logic gst_pick(input logic [NPIN-1:0] v,
                                    input logic [4:0]      idx);
    logic r;
    r = 1'b0;
    for (int k = 0; k < NPIN; k++) begin
      if (5'(k) == idx) begin
        r = v[k];
      end
    end
    return r;
  endfunction : gst_pick

  // aligned, mapped register address
  function automatic logic gst_hit(input logic [GST_AW-1:0] a);
    logic       r;
    logic [4:0] o;
    o = a[4:0];
    r = 1'b0;
    if (a[1:0] == 2'h0) begin
      if (a[7:5] < 3'(GST_TMR_N)) begin
        r = (o <= GST_OFF_GPPS);
      end else if (a[7:5] == GST_INT_PAGE) begin
        r = (o == GST_OFF_STAT) || (o == GST_OFF_MASK);
      end
    end
    return r;
  endfunction : gst_hit

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic                 wr;
    logic                 rd_setup;
    logic [1:0]           ti;
    logic [4:0]           off;
    logic [7:0]           wb;
    logic                 ck;
    logic                 tick;
    logic                 ext;
    logic                 run;
    logic                 glvl;
    logic                 gok;
    logic [2:0]           pmask;
    logic [16:0]          inc;
    logic [GST_TMR_N-1:0] ovf;
    logic [GST_TMR_N-1:0] gval;
    logic                 osc_on;
    logic [31:0]          rd;
    wr       = psel && penable && pwrite && pstrb[0];
    rd_setup = psel && !penable && !pwrite;
    ti       = paddr[6:5];
    off      = paddr[4:0];
    wb       = pwdata[7:0];
    ck       = 1'b0;
    tick     = 1'b0;
    ext      = 1'b0;
    run      = 1'b0;
    glvl     = 1'b0;
    gok      = 1'b0;
    pmask    = 3'h0;
    inc      = 17'h00000;
    ovf      = '0;
    gval     = '0;
    osc_on   = 1'b0;
    rd       = 32'h00000000;
    state_next = state_reg;

    // two-flop synchronisers on every pin and the oscillator input
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sosc1 = low_freq_osc_in;
    state_next.sosc2 = state_reg.sosc1;
    // free divider for the instruction-rate internal source
    state_next.idiv  = state_reg.idiv + 2'h1;

    // per-timer counting, all three built alike
    for (int i = 0; i < GST_TMR_N; i++) begin
      osc_on = osc_on | state_reg.t[i].ctl[GST_SOSC_BIT];
      // clock source selection
      case (gst_cs_t'(state_reg.t[i].ctl[GST_CS_LSB +: 2]))
        GST_CS_PIN: begin
          ck  = gst_pick(state_reg.sync2, state_reg.t[i].ckpps);
          ext = 1'b1;
        end
        GST_CS_SOSC: begin
          ck  = state_reg.sosc2 & state_reg.t[i].ctl[GST_SOSC_BIT];
          ext = 1'b1;
        end
        default: begin
          ck  = 1'b0;
          ext = 1'b0;
        end
      endcase
      state_next.t[i].clk_d  = ck;
      state_next.t[i].clk_d2 = state_reg.t[i].clk_d;
      // rising edge of the counting clock; sync mode adds a stage,
      // so flipping the mode shifts the phase by one sample
      if (!ext) begin
        tick = (state_reg.t[i].ctl[GST_CS_LSB +: 2] == GST_CS_SYS)
             || (state_reg.idiv == GST_INSTR_DIV);
      end else if (state_reg.t[i].ctl[GST_SYNC_BIT]) begin
        tick = ck & ~state_reg.t[i].clk_d;
      end else begin
        tick = state_reg.t[i].clk_d & ~state_reg.t[i].clk_d2;
      end
      // only the unsynchronised external clock survives sleep
      run = state_reg.t[i].ctl[GST_ON_BIT]
          && (!sleep || (ext && state_reg.t[i].ctl[GST_SYNC_BIT]));
      // gate source and polarity
      case (state_reg.t[i].gctl[GST_GSS_LSB +: 2])
        2'h0:    glvl = gst_pick(state_reg.sync2, state_reg.t[i].gpps);
        2'h1:    glvl = gate_aux[0];
        2'h2:    glvl = gate_aux[1];
        default: glvl = gate_aux[2];
      endcase
      gval[i] = glvl;
      gok = !state_reg.t[i].gctl[GST_GE_BIT]
          || (glvl == state_reg.t[i].gctl[GST_GPOL_BIT]);
      // prescale: count on the last event of each group
      pmask = 3'((4'h1 << state_reg.t[i].ctl[GST_PS_LSB +: 2]) - 4'h1);
      inc   = {1'b0, state_reg.t[i].cnt} + 17'h00001;
      if (tick && run && gok) begin
        state_next.t[i].pcnt = state_reg.t[i].pcnt + 3'h1;
        if ((state_reg.t[i].pcnt & pmask) == pmask) begin
          state_next.t[i].cnt = inc[15:0];
          ovf[i] = inc[16];
        end
      end
      // register writes win over the increment in the same cycle;
      // software is expected to stop the timer first
      if (wr && paddr[7:5] == 3'(i) && paddr[1:0] == 2'h0) begin
        case (off)
          GST_OFF_CTL: begin
            state_next.t[i].ctl = wb & GST_CTL_WMASK;
          end
          GST_OFF_GCTL: begin
            state_next.t[i].gctl = wb & GST_GCTL_WMASK;
          end
          GST_OFF_CNTL: begin
            state_next.t[i].cnt[7:0] = wb;
            state_next.t[i].pcnt     = 3'h0;
            ovf[i]                   = 1'b0;
          end
          GST_OFF_CNTH: begin
            state_next.t[i].cnt[15:8] = wb;
            state_next.t[i].pcnt      = 3'h0;
            ovf[i]                    = 1'b0;
          end
          GST_OFF_CKPS: begin
            state_next.t[i].ckpps = wb[4:0] & GST_PPS_WMASK;
          end
          GST_OFF_GPPS: begin
            state_next.t[i].gpps = wb[4:0] & GST_PPS_WMASK;
          end
          default: begin
          end
        endcase
      end
    end

    // oscillator amplifier: inverts the synchronised crystal input while
    // enabled; the raw pin never feeds logic, at the cost of three cycles lag
    state_next.osc_out = osc_on & ~state_reg.sosc2;

    // interrupt status and mask; a set in the clearing cycle wins
    state_next.status = state_reg.status;
    if (wr && paddr[7:5] == GST_INT_PAGE) begin
      if (off == GST_OFF_STAT) begin
        state_next.status = state_reg.status & ~pwdata[GST_TMR_N-1:0];
      end else if (off == GST_OFF_MASK) begin
        state_next.mask = pwdata[GST_TMR_N-1:0];
      end
    end
    state_next.status = state_next.status | ovf;

    // read data is captured in the setup phase; the count lives in
    // the bus clock domain, so a byte read is never torn
    if (rd_setup && gst_hit(paddr)) begin
      if (paddr[7:5] == GST_INT_PAGE) begin
        if (off == GST_OFF_STAT) begin
          rd[GST_TMR_N-1:0] = state_reg.status;
        end else begin
          rd[GST_TMR_N-1:0] = state_reg.mask;
        end
      end else begin
        for (int i = 0; i < GST_TMR_N; i++) begin
          if (ti == 2'(i)) begin
            case (off)
              GST_OFF_CTL:  rd[7:0] = state_reg.t[i].ctl;
              GST_OFF_GCTL: begin
                rd[7:0] = state_reg.t[i].gctl;
                rd[GST_GVAL_BIT] = gval[i];
              end
              GST_OFF_CNTL: rd[7:0] = state_reg.t[i].cnt[7:0];
              GST_OFF_CNTH: rd[7:0] = state_reg.t[i].cnt[15:8];
              GST_OFF_CKPS: rd[4:0] = state_reg.t[i].ckpps;
              GST_OFF_GPPS: rd[4:0] = state_reg.t[i].gpps;
              default:      rd = 32'h00000000;
            endcase
          end
        end
      end
      state_next.prdata = rd;
    end else if (rd_setup) begin
      state_next.prdata = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < GST_TMR_N; i++) begin
        state_reg.t[i].ctl    <= GST_CTL_RST;
        state_reg.t[i].gctl   <= GST_GCTL_RST;
        state_reg.t[i].cnt    <= GST_CNT_RST;
        state_reg.t[i].ckpps  <= GST_PPS_RST;
        state_reg.t[i].gpps   <= GST_PPS_RST;
        state_reg.t[i].pcnt   <= 3'h0;
        state_reg.t[i].clk_d  <= 1'b0;
        state_reg.t[i].clk_d2 <= 1'b0;
      end
      state_reg.status  <= '0;
      state_reg.mask    <= '0;
      state_reg.prdata  <= 32'h00000000;
      state_reg.sync1   <= '0;
      state_reg.sync2   <= '0;
      state_reg.sosc1   <= 1'b0;
      state_reg.sosc2   <= 1'b0;
      state_reg.idiv    <= 2'h0;
      state_reg.osc_out <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave; unmapped or misaligned access answers with error
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !gst_hit(paddr);
  assign prdata           = state_reg.prdata;
  assign low_freq_osc_out = state_reg.osc_out;
  assign irq              = |(state_reg.status & state_reg.mask);
  // a masked-in overflow during sleep asks the core to wake
  assign wake             = sleep && irq;

endmodule : gst_timer

/* File: gst_timer_properties.sv */
// port-level assertions for the gated sixteen-bit timer
`timescale 1ns/1ps

module gst_timer_properties
  import gst_pkg::*;
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [gst_pkg::GST_AW-1:0]  paddr,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        sleep,
  input wire logic                        low_freq_osc_in,
  input wire logic                        low_freq_osc_out,
  input wire logic                        irq,
  input wire logic                        wake
);
  // ----------------------------------------------------------------
  // bus, interrupt and oscillator relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_always_a: assert property (pready)
    else $error("pready dropped");
  wake_sleep_a: assert property (wake == (sleep && irq))
    else $error("wake not sleep and irq");
  misalign_err_a: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  mapped_ok_a: assert property (
    psel && penable && paddr[1:0] == 2'h0 &&
    (paddr[7:5] < 3'h3 ? paddr[4:0] <= GST_OFF_GPPS :
     paddr[7:5] == 3'h3 && paddr[4:0] <= GST_OFF_MASK) |-> !pslverr)
    else $error("mapped register refused");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  osc_out_a: assert property (
    low_freq_osc_out |-> !$past(low_freq_osc_in, 3))
    else $error("oscillator output not inverted input");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(psel && penable && pwrite))
    else $error("interrupt fell without a write");
  read_hold_a: assert property (
    !$stable(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved without a read");
endmodule : gst_timer_properties

bind gst_timer gst_timer_properties i_gst_timer_properties (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .sleep, .low_freq_osc_in, .low_freq_osc_out, .irq, .wake
);

/* File: gst_timer_test.sv */
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ps

module gst_timer_test;
  import gst_pkg::*;
  logic                        pclk = 1'b0;
  logic                        presetn = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [gst_pkg::GST_AW-1:0]  paddr = '0;
  logic [31:0]                 pwdata = '0;
  logic [3:0]                  pstrb = 4'hF;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic [7:0]                  pin_in = '0;
  logic [2:0]                  gate_aux = '0;
  logic                        sleep = 1'b0;
  logic                        osc_in = 1'b0;
  logic                        osc_out;
  logic                        irq;
  logic                        wake;
  logic [31:0]                 rv;
  logic                        err;
  int                          failures = 0;
  int                          samples_checked = 0;
  int                          cycles = 0;

  // ----------------------------------------------------------------
  // design, clock and hang guard
  // ----------------------------------------------------------------
  gst_timer #(.NPIN(8)) i_gst_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .gate_aux(gate_aux), .sleep(sleep),
    .low_freq_osc_in(osc_in), .low_freq_osc_out(osc_out),
    .irq(irq), .wake(wake));

  always #5 pclk = ~pclk;

  // a stuck handshake ends the run here instead of hanging
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer plus an idle edge, so psel never rises twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rd

  function automatic logic [7:0] ra(input int n, input logic [4:0] off);
    return {3'(n), off};
  endfunction : ra

  // callers stop the timer first, so a write never races an increment
  task automatic setcnt(input int n, input logic [15:0] v);
    wr(ra(n, GST_OFF_CNTL), v[7:0]);
    wr(ra(n, GST_OFF_CNTH), v[15:8]);
  endtask : setcnt

  // slow edges on the clock pin and the oscillator input together
  task automatic pulses(input int k);
    repeat (k) begin
      pin_in[3] <= 1'b1;
      osc_in <= 1'b1;
      repeat (6) @(posedge pclk);
      pin_in[3] <= 1'b0;
      osc_in <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : pulses

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int n = 0; n < 3; n++) begin
      rd(ra(n, GST_OFF_CTL));
      check(rv, 32'h0);
      setcnt(n, 16'h5AA5);
      rd(ra(n, GST_OFF_CNTL));
      check(rv, 32'hA5);
      rd(ra(n, GST_OFF_CNTH));
      check(rv, 32'h5A);
      // a write without its low byte strobe must leave the count alone
      pstrb <= 4'h0;
      wr(ra(n, GST_OFF_CNTL), 8'h11);
      pstrb <= 4'hF;
      rd(ra(n, GST_OFF_CNTL));
      check(rv, 32'hA5);
      wr(ra(n, GST_OFF_CTL), 8'hF4);
      rd(ra(n, GST_OFF_CTL));
      check(rv, 32'hF4);
    end
    rd(8'h18);
    check({rv[31:1], err}, 32'h1);
    rd(8'h02);
    check({rv[31:1], err}, 32'h1);
    $display("register test done");
  endtask : t_regs

  task automatic t_ovf;
    wr(8'h64, 8'h07);
    for (int n = 0; n < 3; n++) begin
      setcnt(n, 16'hFFF0);
      wr(ra(n, GST_OFF_CTL), 8'h41);
      repeat (30) @(posedge pclk);
      wr(ra(n, GST_OFF_CTL), 8'h40);
      rd(8'h60);
      check(rv, 32'h1 << n);
      check(irq, 1'b1);
      wr(8'h64, 8'h00);
      check(irq, 1'b0);
      wr(8'h64, 8'h07);
      wr(8'h60, 8'(1 << n));
      check(irq, 1'b0);
    end
    $display("overflow test done");
  endtask : t_ovf

  task automatic t_presc;
    logic [7:0] lo;
    for (int ps = 0; ps < 4; ps++) begin
      setcnt(0, 16'h0000);
      wr(ra(0, GST_OFF_CTL), 8'h41 | 8'(ps << 4));
      repeat (64) @(posedge pclk);
      wr(ra(0, GST_OFF_CTL), 8'h40);
      rd(ra(0, GST_OFF_CNTL));
      lo = rv[7:0];
      // 64 idle edges plus three ticks inside the start and stop writes
      check(lo, 8'(67 >> ps));
      repeat (9) @(posedge pclk);
      rd(ra(0, GST_OFF_CNTL));
      check(rv[7:0], lo);
    end
    $display("prescale test done");
  endtask : t_presc

  // a stopped timer keeps a part-filled prescaler; a count write empties it
  task automatic t_pclr;
    setcnt(0, 16'h0000);
    wr(ra(0, GST_OFF_CTL), 8'h71);
    wr(ra(0, GST_OFF_CTL), 8'h70); // three ticks: prescaler at three
    wr(ra(0, GST_OFF_CNTL), 8'h00);
    wr(ra(0, GST_OFF_CTL), 8'h71);
    repeat (4) @(posedge pclk);
    wr(ra(0, GST_OFF_CTL), 8'h70); // seven ticks: one short of a count
    rd(ra(0, GST_OFF_CNTL));
    check(rv, 32'h0);
    wr(ra(0, GST_OFF_CTL), 8'h71);
    wr(ra(0, GST_OFF_CTL), 8'h70); // the eighth tick lands
    rd(ra(0, GST_OFF_CNTL));
    check(rv, 32'h1);
    $display("prescale clear test done");
  endtask : t_pclr

  // gate level onto pin 5 for source 0, else onto one aux line
  task automatic gate_drive(input int s, input logic v);
    if (s == 0) begin
      pin_in[5] <= v;
    end else begin
      gate_aux[s-1] <= v;
    end
  endtask : gate_drive

  // every gate source and polarity; the pin source lags by its synchroniser
  task automatic t_gate;
    wr(ra(0, GST_OFF_GPPS), 8'h05);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        gate_drive(s, !p[0]);
        wr(ra(0, GST_OFF_GCTL), 8'h80 | 8'(p << 6) | 8'(s));
        setcnt(0, 16'h0000);
        wr(ra(0, GST_OFF_CTL), 8'h41);
        rd(ra(0, GST_OFF_GCTL));
        check(rv[2], !p[0]);
        rd(ra(0, GST_OFF_CNTL));
        check(rv, 32'h0);
        gate_drive(s, p[0]);
        repeat (8) @(posedge pclk);
        rd(ra(0, GST_OFF_CNTL));
        check(rv, (s == 0) ? 32'h06 : 32'h08);
        wr(ra(0, GST_OFF_CTL), 8'h40);
      end
      gate_drive(s, 1'b0);
    end
    $display("gate test done");
  endtask : t_gate

  // synced, unsynced, then unsynced asleep: five pin edges each time
  task automatic t_pin;
    wr(ra(0, GST_OFF_GCTL), 8'h00);
    wr(ra(0, GST_OFF_CKPS), 8'h03);
    for (int k = 0; k < 3; k++) begin
      setcnt(0, 16'hFFFE);
      wr(ra(0, GST_OFF_CTL), 8'h81 | 8'((k != 0) << 2));
      sleep <= (k == 2);
      pulses(5);
      check(wake, k == 2);
      sleep <= 1'b0;
      rd(ra(0, GST_OFF_CNTL));
      check(rv, 32'h03);
      wr(ra(0, GST_OFF_CTL), 8'h80);
      wr(8'h60, 8'h01);
    end
    $display("pin clock test done");
  endtask : t_pin

  task automatic t_osc;
    setcnt(0, 16'h0000);
    wr(ra(0, GST_OFF_CTL), 8'hC9);
    pulses(4);
    check(osc_out, 1'b1);
    rd(ra(0, GST_OFF_CNTL));
    check(rv, 32'h04);
    wr(ra(0, GST_OFF_CTL), 8'h00);
    $display("oscillator test done");
  endtask : t_osc

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_ovf();
    t_presc();
    t_pclr();
    t_gate();
    t_pin();
    t_osc();
    results();
  end
endmodule : gst_timer_test
